// file: rtl/bb_ctrl_pkg.sv
// Purpose: shared constants and types for the buck-boost control logic
// Assumes: analog comparators arrive as synchronous digital levels
// Notes:   register offsets are the printed byte offsets on the serial bus
package bb_ctrl_pkg;

  localparam int unsigned CLK_FREQ_HZ = 25_000_000;

  // target addresses chosen by the address strap
  localparam logic [6:0] ADDR_STRAP_LOW  = 7'h75;
  localparam logic [6:0] ADDR_STRAP_HIGH = 7'h74;

  // register offsets
  localparam logic [7:0] OFS_REF_FIRST  = 8'h00;
  localparam logic [7:0] OFS_REF_SECOND = 8'h01;
  localparam logic [7:0] OFS_FB_SELECT  = 8'h04;
  localparam logic [7:0] OFS_OUT_CTRL   = 8'h06;

  // reset values
  localparam logic [7:0] RST_REF_FIRST  = 8'h00;
  localparam logic [7:0] RST_REF_SECOND = 8'h00;
  localparam logic [7:0] RST_FB_SELECT  = 8'h00;
  localparam logic [7:0] RST_OUT_CTRL   = 8'h00;

  // field positions
  localparam int unsigned REF_CODE_W      = 11;
  localparam int unsigned REF_HI_W        = 3;
  localparam int unsigned FB_SRC_BIT      = 7;
  localparam int unsigned FB_RATIO_LSB    = 0;
  localparam int unsigned OUT_SW_EN_BIT   = 7;
  localparam int unsigned OUT_FDIS_BIT    = 5;
  localparam int unsigned OUT_DIS_BIT     = 4;

  // soft-start duration
  localparam real         SOFT_START_MS   = 3.6;
  localparam int unsigned SOFT_START_CYC  = int'(SOFT_START_MS * CLK_FREQ_HZ / 1000.0);

  typedef enum logic [1:0] {
    ST_SHUTDOWN = 2'b00,
    ST_STANDBY  = 2'b01,
    ST_ACTIVE   = 2'b11
  } power_state_type;

  // analog comparator levels
  typedef struct packed {
    logic vin_above_lockout;   // input above 3V rising / not below 2.6V
    logic en_above_shutdown;   // enable pin above 0.4V
    logic en_above_standby;    // enable pin above 1.15V
    logic en_above_active;     // enable pin above 1.23V
    logic vin_above_62;
    logic vin_below_59;
    logic vout_above_62;
    logic vout_below_59;
    logic vout_above_vin;
    logic vout_below_08;
    logic dith_below_04;
    logic dith_above_12;
    logic sync_clock_present;
  } sense_type;

  // register write port from the serial-bus target
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_type;

endpackage : bb_ctrl_pkg

// file: rtl/soft_start_ramp.sv
// Purpose: ramps the reference code from zero to its target
// Assumes: i_start held high while switching is enabled
// Notes:   the step interval spreads the ramp over the soft-start time
`timescale 1ns/10ps
module soft_start_ramp
  import bb_ctrl_pkg::*;
#(
  parameter int unsigned CODE_W    = REF_CODE_W,
  parameter int unsigned RAMP_CYC  = SOFT_START_CYC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_start,
  input  wire logic [CODE_W-1:0] i_target,
  output logic      [CODE_W-1:0] o_code,
  output logic                   o_done
);

  localparam int unsigned STEPS   = (1 << CODE_W);
  localparam int unsigned STEP_IV = (RAMP_CYC / STEPS > 0) ? RAMP_CYC / STEPS : 1;
  localparam int unsigned DIV_W   = $clog2(STEP_IV + 1);

  logic [DIV_W-1:0] div_cnt;
  logic             step_en;

  assign step_en = (div_cnt == DIV_W'(STEP_IV - 1));
  assign o_done  = i_start && (o_code == i_target);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_start || step_en) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_start) begin
      o_code <= '0;
    end else if (o_code > i_target) begin
      o_code <= i_target;
    end else if (step_en && o_code < i_target) begin
      o_code <= o_code + CODE_W'(1);
    end
  end

endmodule : soft_start_ramp

// file: rtl/buck_boost_control_logic.sv
// Purpose: enable, standby, shutdown and register control of the buck-boost regulator
// Assumes: comparator levels and the register write port are synchronous to i_clk
// Notes:   register writes come from the serial-bus target, which is gated by o_bus_enable
//
// Functional notes
// - standby state samples address strap pin
// - strap low 75h, strap high 74h
// - above active threshold: bus and switching allowed
// - disabled until input supply clears lockout
// - switching enable ramps reference over 3.6ms
// - shutdown disables bus, switching and discharge, resets registers
// - switching bit clear stops switching only
// - discharge-on-disable sinks until output below 0.8V
// - forced discharge on whenever its bit is set in active state
// - feedback source: 0 internal, 1 external
// - two-bit field picks internal divider ratio
// - eleven-bit reference code over two registers
// - external supply when select pin low
// - LDO source by hysteretic 6.2V/5.9V comparators
// - dithering off outside window or synced
`timescale 1ns/10ps
module buck_boost_control_logic
  import bb_ctrl_pkg::*;
#(
  parameter int unsigned RAMP_CYC = SOFT_START_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  input  wire sense_type             i_sense,
  input  wire logic                  i_address_strap,
  input  wire logic                  i_external_supply_select,
  input  wire reg_write_type         i_reg_wr,
  input  wire logic [7:0]            i_reg_rd_addr,
  output logic      [7:0]            o_reg_rd_data,
  output logic      [6:0]            o_target_address,
  output logic                       o_bus_enable,
  output logic                       o_switching_enable,
  output logic      [REF_CODE_W-1:0] o_reference_code,
  output logic                       o_soft_start_done,
  output logic                       o_feedback_source_select,
  output logic      [1:0]            o_internal_divider_ratio,
  output logic                       o_discharge_on,
  output logic                       o_use_external_supply,
  output logic                       o_ldo_from_vout,
  output logic                       o_dither_enable,
  output logic      [1:0]            o_power_state
);

  ////////////////////////////////////////////////////////////////////////////
  power_state_type state;
  power_state_type next_state;
  logic [7:0]      ref_first;
  logic [7:0]      ref_second;
  logic [7:0]      fb_sel;
  logic [7:0]      out_ctrl;
  logic            addr_latched;
  logic            ldo_vout;
  logic            regs_clear;
  logic            wr_ok;
  logic            sw_bit;
  logic [REF_CODE_W-1:0] ref_target;
  logic [REF_CODE_W-1:0] ramp_code;

  always_comb begin
    next_state = state;
    case (state)
      ST_SHUTDOWN: begin
        if (i_sense.vin_above_lockout && i_sense.en_above_standby) begin
          next_state = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (!i_sense.vin_above_lockout || !i_sense.en_above_shutdown) begin
          next_state = ST_SHUTDOWN;
        end else if (i_sense.en_above_active) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!i_sense.vin_above_lockout || !i_sense.en_above_shutdown) begin
          next_state = ST_SHUTDOWN;
        end else if (!i_sense.en_above_active) begin
          next_state = ST_STANDBY;
        end
      end
      default: next_state = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= ST_SHUTDOWN;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address strap: caught on the first standby cycle, held until shutdown
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || state == ST_SHUTDOWN) begin
      addr_latched     <= 1'b0;
      o_target_address <= ADDR_STRAP_LOW;
    end else if (state == ST_STANDBY && !addr_latched) begin
      addr_latched     <= 1'b1;
      o_target_address <= i_address_strap ? ADDR_STRAP_HIGH : ADDR_STRAP_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign regs_clear = !i_rst_b || state == ST_SHUTDOWN;
  assign wr_ok      = i_reg_wr.wr && state == ST_ACTIVE;

  always_ff @(posedge i_clk) begin
    if (regs_clear) begin
      ref_first <= RST_REF_FIRST;
    end else if (wr_ok && i_reg_wr.addr == OFS_REF_FIRST) begin
      ref_first <= i_reg_wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (regs_clear) begin
      ref_second <= RST_REF_SECOND;
    end else if (wr_ok && i_reg_wr.addr == OFS_REF_SECOND) begin
      ref_second <= i_reg_wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (regs_clear) begin
      fb_sel <= RST_FB_SELECT;
    end else if (wr_ok && i_reg_wr.addr == OFS_FB_SELECT) begin
      fb_sel <= i_reg_wr.data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (regs_clear) begin
      out_ctrl <= RST_OUT_CTRL;
    end else if (wr_ok && i_reg_wr.addr == OFS_OUT_CTRL) begin
      out_ctrl <= i_reg_wr.data;
    end
  end

  always_comb begin
    case (i_reg_rd_addr)
      OFS_REF_FIRST:  o_reg_rd_data = ref_first;
      OFS_REF_SECOND: o_reg_rd_data = ref_second;
      OFS_FB_SELECT:  o_reg_rd_data = fb_sel;
      OFS_OUT_CTRL:   o_reg_rd_data = out_ctrl;
      default:        o_reg_rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // low byte full, upper three bits in the second register
  assign ref_target = {ref_second[REF_HI_W-1:0], ref_first};
  assign sw_bit     = out_ctrl[OUT_SW_EN_BIT] && state == ST_ACTIVE;

  soft_start_ramp #(
    .CODE_W   (REF_CODE_W),
    .RAMP_CYC (RAMP_CYC)
  ) u_ramp (
    .i_clk    (i_clk),
    .i_rst_b  (i_rst_b),
    .i_start  (sw_bit),
    .i_target (ref_target),
    .o_code   (ramp_code),
    .o_done   (o_soft_start_done)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_bus_enable             <= 1'b0;
      o_switching_enable       <= 1'b0;
      o_reference_code         <= '0;
      o_feedback_source_select <= 1'b0;
      o_internal_divider_ratio <= 2'b00;
    end else begin
      o_bus_enable             <= next_state == ST_ACTIVE;
      o_switching_enable       <= sw_bit;
      o_reference_code         <= ramp_code;
      o_feedback_source_select <= fb_sel[FB_SRC_BIT];
      o_internal_divider_ratio <= fb_sel[FB_RATIO_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || state != ST_ACTIVE) begin
      o_discharge_on <= 1'b0;
    end else begin
      o_discharge_on <= out_ctrl[OUT_FDIS_BIT]
                     || (!out_ctrl[OUT_SW_EN_BIT] && out_ctrl[OUT_DIS_BIT] && !i_sense.vout_below_08);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LDO source: the lower rail wins once above 6.2V, drops back below 5.9V
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ldo_vout <= 1'b0;
    end else if (i_sense.vout_above_vin) begin
      if (i_sense.vin_above_62) begin
        ldo_vout <= 1'b0;
      end else if (i_sense.vin_below_59) begin
        ldo_vout <= 1'b1;
      end
    end else begin
      if (i_sense.vout_above_62) begin
        ldo_vout <= 1'b1;
      end else if (i_sense.vout_below_59) begin
        ldo_vout <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_ldo_from_vout       <= 1'b0;
      o_use_external_supply <= 1'b0;
      o_dither_enable       <= 1'b0;
      o_power_state         <= ST_SHUTDOWN;
    end else begin
      o_ldo_from_vout       <= ldo_vout;
      o_use_external_supply <= !i_external_supply_select;
      o_dither_enable       <= !i_sense.dith_below_04 && !i_sense.dith_above_12
                            && !i_sense.sync_clock_present;
      o_power_state         <= state;
    end
  end

endmodule : buck_boost_control_logic

// file: test/bb_ctrl_monitor.sv
// Purpose: port-level checks on the buck-boost control logic
// Assumes: one clock domain, synchronous active-low reset
// Notes:   attached by bind below
`timescale 1ns/10ps
module bb_ctrl_monitor
  import bb_ctrl_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst_b,
  input wire sense_type             i_sense,
  input wire logic                  i_external_supply_select,
  input wire logic [6:0]            o_target_address,
  input wire logic                  o_bus_enable,
  input wire logic                  o_switching_enable,
  input wire logic [REF_CODE_W-1:0] o_reference_code,
  input wire logic                  o_discharge_on,
  input wire logic                  o_use_external_supply,
  input wire logic                  o_dither_enable,
  input wire logic [1:0]            o_power_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence sw_rise;
    !o_switching_enable ##1 o_switching_enable;
  endsequence
  sequence live2;
    o_power_state == ST_ACTIVE ##1 o_power_state == ST_ACTIVE;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  addr_hold_a: assert property (o_power_state != ST_SHUTDOWN && $past(o_power_state) != ST_SHUTDOWN
    && $past(o_power_state, 2) != ST_SHUTDOWN |-> $stable(o_target_address)) else $error("address moved");
  shut_clear_a: assert property (o_power_state == ST_SHUTDOWN [*2] |-> !o_switching_enable && !o_bus_enable
    && !o_discharge_on) else $error("output live in shutdown");
  // the state output trails the state register by one cycle, so shutdown shows two edges on
  vin_lockout_a: assert property (!i_sense.vin_above_lockout |-> ##2 o_power_state == ST_SHUTDOWN)
    else $error("lockout");
  // bus enable follows the next state, one cycle ahead of the state output
  bus_gate_a: assert property ((o_power_state == ST_ACTIVE) == $past(o_bus_enable)) else $error("bus gate");
  sw_gate_a: assert property (o_switching_enable |-> o_power_state == ST_ACTIVE) else $error("sw gate");
  ramp_start_a: assert property (sw_rise |-> o_reference_code <= 11'h002) else $error("ramp start");
  ramp_step_a: assert property (o_switching_enable && $past(o_switching_enable)
    |-> {1'b0, o_reference_code} <= {1'b0, $past(o_reference_code)} + 12'h001) else $error("ramp step");
  dither_off_a: assert property (o_power_state == ST_ACTIVE && (i_sense.dith_below_04 || i_sense.dith_above_12
    || i_sense.sync_clock_present) |=> !o_dither_enable) else $error("dither on");
  ext_sup_a: assert property (live2 |-> o_use_external_supply == !$past(i_external_supply_select))
    else $error("supply select");
  disc_gate_a: assert property (o_discharge_on |-> o_power_state == ST_ACTIVE) else $error("discharge");
endmodule : bb_ctrl_monitor

bind buck_boost_control_logic bb_ctrl_monitor mon (.*);

// file: test/bus_ctrl_model.sv
// Purpose: serial-bus controller model issuing register writes
// Assumes: one write strobe per call
// Notes:   drives on falling edges
`timescale 1ns/10ps
module bus_ctrl_model
  import bb_ctrl_pkg::*;
(
  input  wire logic     i_clk,
  output reg_write_type o_reg_wr
);
  initial o_reg_wr = '0;
  // each call raises the write strobe on one falling edge and drops it on the next
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk) o_reg_wr <= '{1'b1, a, d};
    @(negedge i_clk) o_reg_wr <= '0;
  endtask : put
endmodule : bus_ctrl_model

// file: test/tb_top.sv
// Purpose: self-checking bench for the buck-boost control logic
// Assumes: ramp parameter shortened to 4096 cycles
// Notes:   inputs change on falling edges
`timescale 1ns/10ps
module tb_top;
  import bb_ctrl_pkg::*;
  localparam int unsigned RC = 4096;
  logic i_clk, i_rst_b, i_address_strap, i_external_supply_select;
  sense_type i_sense;
  reg_write_type i_reg_wr;
  logic [7:0] i_reg_rd_addr, o_reg_rd_data;
  logic [6:0] o_target_address;
  logic o_bus_enable, o_switching_enable, o_soft_start_done, o_feedback_source_select;
  logic o_discharge_on, o_use_external_supply, o_ldo_from_vout, o_dither_enable;
  logic [REF_CODE_W-1:0] o_reference_code;
  logic [1:0] o_internal_divider_ratio, o_power_state;
  int err_total, checks_done, n;
  logic [31:0] v;
  logic [10:0] r;
  logic ldo_exp;
  buck_boost_control_logic #(.RAMP_CYC(RC)) dut (.*);
  bus_ctrl_model bc (.i_clk, .o_reg_wr(i_reg_wr));
  always #20 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // 0 shutdown, 1 standby, 2 active
  task automatic lvl(input int l);
    @(negedge i_clk);
    i_sense.vin_above_lockout = 1;
    i_sense.en_above_shutdown = l > 0;
    i_sense.en_above_standby = l > 0;
    i_sense.en_above_active = l > 1;
    repeat (3) @(negedge i_clk);
  endtask : lvl
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_reg_rd_addr = a;
    #1 chk("read", o_reg_rd_data, e);
  endtask : rd
  function automatic logic ldo_next(input logic [31:0] x, input logic p);
    if (x[5]) return x[6] ? 1'b0 : (x[7] ? 1'b1 : p);
    return x[8] ? 1'b1 : (x[9] ? 1'b0 : p);
  endfunction : ldo_next
  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 0;
    i_rst_b = 0;
    i_sense = '0;
    i_address_strap = 1;
    i_external_supply_select = 1;
    i_reg_rd_addr = 0;
    err_total = 0;
    checks_done = 0;
    ldo_exp = 0;
    void'($urandom(20));
    repeat (12) @(negedge i_clk);
    i_rst_b = 1;
    chk("addr", o_target_address, 7'h75);
    lvl(1);
    chk("state", o_power_state, ST_STANDBY);
    chk("addr", o_target_address, ADDR_STRAP_HIGH);
    i_address_strap = 0;
    bc.put(OFS_OUT_CTRL, 8'h80);
    rd(OFS_OUT_CTRL, 0);
    lvl(2);
    chk("addr", o_target_address, ADDR_STRAP_HIGH);
    chk("bus", o_bus_enable, 1);
    for (int i = 0; i < 8; i++) begin
      bc.put(OFS_FB_SELECT, {i[2], 5'h0, i[1:0]});
      @(negedge i_clk);
      chk("fb", o_feedback_source_select, i[2]);
      chk("ratio", o_internal_divider_ratio, i[1:0]);
    end
    bc.put(8'h02, 8'hff);
    rd(8'h02, 0);
    r = 11'($urandom_range(2047, 1200));
    bc.put(OFS_REF_FIRST, r[7:0]);
    bc.put(OFS_REF_SECOND, {5'h0, r[10:8]});
    rd(OFS_REF_FIRST, r[7:0]);
    bc.put(OFS_OUT_CTRL, 8'h80);
    n = 0;
    while (o_soft_start_done !== 1'b1 && n < 2 * RC) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 2 * RC) begin
      err_total++;
      report_and_stop();
    end
    chk("ramp", n >= 2 * r - 8 && n <= 2 * r + 8, 1);
    // the reference output is registered one cycle behind the ramp
    @(negedge i_clk);
    chk("code", o_reference_code, r);
    chk("sw", o_switching_enable, 1);
    bc.put(OFS_OUT_CTRL, 8'h10);
    repeat (2) @(negedge i_clk);
    chk("sw off", o_switching_enable, 0);
    chk("bus", o_bus_enable, 1);
    chk("dis", o_discharge_on, 1);
    i_sense.vout_below_08 = 1;
    repeat (2) @(negedge i_clk);
    chk("dis stop", o_discharge_on, 0);
    bc.put(OFS_OUT_CTRL, 8'ha0);
    repeat (2) @(negedge i_clk);
    chk("force", o_discharge_on, 1);
    bc.put(OFS_OUT_CTRL, 8'h00);
    for (int k = 0; k < 60; k++) begin
      v = $urandom;
      i_sense.dith_below_04 = v[0];
      i_sense.dith_above_12 = v[1] & !v[0];
      i_sense.sync_clock_present = v[2] & v[3];
      i_external_supply_select = v[4];
      i_sense.vout_above_vin = v[5];
      i_sense.vin_above_62 = v[6];
      i_sense.vin_below_59 = !v[6] & v[7];
      i_sense.vout_above_62 = v[8];
      i_sense.vout_below_59 = !v[8] & v[9];
      ldo_exp = ldo_next(v, ldo_exp);
      repeat (2) @(negedge i_clk);
      chk("dither", o_dither_enable, !(v[0] | v[1] | (v[2] & v[3])));
      chk("ext", o_use_external_supply, !v[4]);
      chk("ldo", o_ldo_from_vout, ldo_exp);
    end
    lvl(0);
    chk("state", o_power_state, ST_SHUTDOWN);
    lvl(1);
    rd(OFS_REF_FIRST, RST_REF_FIRST);
    chk("addr", o_target_address, ADDR_STRAP_LOW);
    i_sense.vin_above_lockout = 0;
    repeat (2) @(negedge i_clk);
    chk("lockout", o_power_state, ST_SHUTDOWN);
    report_and_stop();
  end
endmodule : tb_top
